// ==== shared/dapc_pkg.sv ====
`default_nettype none
package dapc_pkg;
    // Three-level strap states
    typedef enum logic [1:0] {
        DAPC_STRAP_LOW   = 2'b00,
        DAPC_STRAP_FLOAT = 2'b01,
        DAPC_STRAP_HIGH  = 2'b10
    } dapc_strap_e;

    // Clock divide selections
    localparam logic [1:0] DAPC_DIV1 = 2'h0;
    localparam logic [1:0] DAPC_DIV2 = 2'h1;
    localparam logic [1:0] DAPC_DIV4 = 2'h2;

    // Output standard selections
    localparam logic [1:0] DAPC_OUT_CMOS   = 2'h0;
    localparam logic [1:0] DAPC_OUT_DIFF3  = 2'h1;
    localparam logic [1:0] DAPC_OUT_DIFF2  = 2'h2;

    // Code formats
    localparam logic [1:0] DAPC_FMT_OFFBIN = 2'h0;
    localparam logic [1:0] DAPC_FMT_TWOS   = 2'h1;
    localparam logic [1:0] DAPC_FMT_GRAY   = 2'h2;

    // Power states
    localparam logic [1:0] DAPC_PWR_NORMAL = 2'h0;
    localparam logic [1:0] DAPC_PWR_SLEEP  = 2'h1;
    localparam logic [1:0] DAPC_PWR_NAP    = 2'h2;

    localparam int DAPC_WORD_W  = 10;
    localparam int DAPC_FIFO_D  = 16;
    localparam int DAPC_LAT_HALF = 15;   // Seven and one half cycles, in half cycles

    // Timing in nanoseconds and clock rate
    localparam int DAPC_CLK_MHZ       = 40;
    localparam int DAPC_NAP_WAKE_NS   = 1000;
    localparam int DAPC_SLEEP_WAKE_NS = 1000000;
    localparam int DAPC_DLL_LOCK_NS   = 52000;
    localparam int DAPC_NAP_WAKE_CYC   = DAPC_NAP_WAKE_NS * DAPC_CLK_MHZ / 1000;
    localparam int DAPC_SLEEP_WAKE_CYC = DAPC_SLEEP_WAKE_NS * DAPC_CLK_MHZ / 1000;
    localparam int DAPC_DLL_LOCK_CYC   = DAPC_DLL_LOCK_NS * DAPC_CLK_MHZ / 1000;

    // Serial override settings, each with a valid flag
    typedef struct packed {
        logic       div_ovr;
        logic [1:0] div_val;
        logic       mode_ovr;
        logic [1:0] mode_val;
        logic       fmt_ovr;
        logic [1:0] fmt_val;
        logic       pwr_ovr;
        logic [1:0] pwr_val;
        logic       pwr_idx_b;
    } dapc_ovr_s;

    // One converted sample pair
    typedef struct packed {
        logic [DAPC_WORD_W-1:0] a;
        logic [DAPC_WORD_W-1:0] b;
    } dapc_pair_s;
endpackage
`default_nettype wire

// ==== logic/dapc_fifo.sv ====
`default_nettype none
module dapc_fifo #(
    parameter int WIDTH = 20,
    parameter int DEPTH = 16
) (
    input  wire logic             mclk,
    input  wire logic             rst_b,
    input  wire logic [WIDTH-1:0] in_data,
    input  wire logic             in_valid,
    output logic                  in_ready,
    output logic [WIDTH-1:0]      out_data,
    output logic                  out_valid,
    input  wire logic             out_ready
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0]    wr_ptr_reg;
    logic [AW-1:0]    rd_ptr_reg;
    logic [AW:0]      count_reg;
    logic             push;
    logic             pop;

    // Honest flags straight from the fill count
    assign in_ready  = (count_reg != (AW+1)'(DEPTH));
    assign out_valid = (count_reg != '0);
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;
    assign out_data  = mem[rd_ptr_reg];

    // Storage has no reset, saves area
    always_ff @(posedge mclk) begin
        if (push) begin
            mem[wr_ptr_reg] <= in_data;
        end
    end

    // Pointers and count
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            wr_ptr_reg <= '0;
            rd_ptr_reg <= '0;
            count_reg  <= '0;
        end else begin
            if (push) begin
                wr_ptr_reg <= (wr_ptr_reg == AW'(DEPTH-1)) ? '0 : wr_ptr_reg + 1'b1;
            end
            if (pop) begin
                rd_ptr_reg <= (rd_ptr_reg == AW'(DEPTH-1)) ? '0 : rd_ptr_reg + 1'b1;
            end
            count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule
`default_nettype wire

// ==== logic/dapc_ctrl.sv ====
`default_nettype none
// Overview of operation
// [R01] Divider strap low divides by 2, floating by 1, high by 4.
// [R02] Serially programmed divider ratio replaces the divider strap.
// [R03] Clock ratio change causes a lock wait, scaled to sample rate; code waits only for a change made in ST_RUN.
// [R04] One DDR bus: channel A while clock low, B while high.
// [R05] Output standard strap: low CMOS, float diff 3mA, high diff 2mA.
// [R06] Serial output standard setting beats the strap.
// [R07] Over-range flags positive full scale, saturates, refreshed every sample.
// [R08] Ready about 1us after nap, about 1ms after sleep exit.
// [R09] Host wakes sleep: select low, wait, write, wait 1ms.
// [R10] With select low in sleep, skip select wait; 1ms still applies.
// [R11] Host keeps select high while device sleeps.
// [R12] Nap or sleep floats data, forwarded clock and over-range; code floats data only, holds clock low, keeps driving over-range.
// [R13] Host keeps input clock steady in low power; stop adds relock.
// [R14] Power strap: low normal, float sleep, high nap.
// [R15] Serial power state overrides strap, indexed; strap acts on both.
// [R16] Format strap: low offset binary, float two's complement, high Gray.
// [R17] Serial format setting supersedes the format strap.
// [R18] Offset binary is straight code; two's complement flips the MSB.
// [R19] Gray keeps MSB; lower bits xor with next higher binary bit.
// [R20] Mid-scale gives 1000000000, 0000000000, 1100000000 per format.
// [R21] Data leaves seven and a half cycles after its sample.
// [R22] Recal reset low holds forwarded clock low; resumes next edge.
// [R23] Ten-bit words, encoded per channel before interleaving.
// [R24] Straps sampled as three states, held, used only without override.
module dapc_ctrl
    import dapc_pkg::*;
#(
    parameter int W          = DAPC_WORD_W,
    parameter int FIFO_DEPTH = DAPC_FIFO_D,
    parameter int SLEEP_CYC  = DAPC_SLEEP_WAKE_CYC,
    parameter int LOCK_CYC   = DAPC_DLL_LOCK_CYC
) (
    input  wire logic          mclk,
    input  wire logic          rst_b,
    input  wire logic [1:0]    clock_divide_strap,
    input  wire logic [1:0]    output_standard_strap,
    input  wire logic [1:0]    code_format_strap,
    input  wire logic [1:0]    power_state_strap,
    input  wire dapc_ovr_s     serial_ovr,
    input  wire logic          serial_select_n,
    input  wire logic          recal_reset_n,
    input  wire logic [W-1:0]  raw_a,
    input  wire logic [W-1:0]  raw_b,
    input  wire logic          raw_valid,
    output logic               raw_ready,
    output logic [W-1:0]       out_data,
    output logic               out_data_oe,
    output logic               forwarded_sample_clock,
    output logic               over_range,
    output logic [1:0]         out_standard,
    output logic [1:0]         divide_ratio,
    output logic [1:0]         power_state_a,
    output logic [1:0]         power_state_b,
    output logic               awake
);
    typedef enum logic [1:0] {
        ST_LOW   = 2'b00,
        ST_WAKE  = 2'b01,
        ST_RUN   = 2'b11,
        ST_LOCK  = 2'b10
    } dapc_pwr_e;

    localparam int NAP_CYC = (DAPC_NAP_WAKE_CYC < 1) ? 1 : DAPC_NAP_WAKE_CYC;
    localparam int CW = $clog2(SLEEP_CYC + LOCK_CYC + NAP_CYC + 1);
    localparam logic [W-1:0] FULL_SCALE = {W{1'b1}};
    localparam logic [1:0]   DIV4_LAST  = 2'h3;

    logic [1:0]  div_sync1_reg, div_sync2_reg, mode_sync1_reg, mode_sync2_reg;
    logic [1:0]  fmt_sync1_reg, fmt_sync2_reg, pwr_sync1_reg, pwr_sync2_reg;
    logic [1:0]  sel_sync_reg, rcl_sync_reg;
    logic [1:0]  div_strap_reg, mode_strap_reg, fmt_strap_reg, pwr_strap_reg;
    logic        straps_held_reg;
    logic [1:0]  div_sel, fmt_sel, pwr_a_sel, pwr_b_sel;
    logic [1:0]  pwr_a_reg, pwr_b_reg;
    logic [1:0]  div_cnt_reg, div_last_reg;
    logic        sample_en;
    dapc_pwr_e   pwr_st_reg;
    logic [CW-1:0] wait_reg;
    logic [W-1:0] enc_a, enc_b;
    dapc_pair_s  fifo_in, fifo_out;
    logic        fifo_out_valid, fifo_pop;
    logic [DAPC_LAT_HALF/2-1:0] lat_valid_reg;
    logic        phase_reg;
    logic        pend_reg, deep_reg;
    logic [W-1:0] hold_b_reg;
    logic        or_b_reg;

    // Two-flop synchronisers for the strap, select and recal inputs
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_sync1_reg  <= 2'h0;
            div_sync2_reg  <= 2'h0;
            mode_sync1_reg <= 2'h0;
            mode_sync2_reg <= 2'h0;
            fmt_sync1_reg  <= 2'h0;
            fmt_sync2_reg  <= 2'h0;
            pwr_sync1_reg  <= 2'h0;
            pwr_sync2_reg  <= 2'h0;
            sel_sync_reg   <= 2'h3;
            rcl_sync_reg   <= 2'h0;
        end else begin
            div_sync1_reg  <= clock_divide_strap;
            div_sync2_reg  <= div_sync1_reg;
            mode_sync1_reg <= output_standard_strap;
            mode_sync2_reg <= mode_sync1_reg;
            fmt_sync1_reg  <= code_format_strap;
            fmt_sync2_reg  <= fmt_sync1_reg;
            pwr_sync1_reg  <= power_state_strap;
            pwr_sync2_reg  <= pwr_sync1_reg;
            sel_sync_reg   <= {sel_sync_reg[0], serial_select_n};
            rcl_sync_reg   <= {rcl_sync_reg[0], recal_reset_n};
        end
    end

    // Straps caught once after reset release and held stable
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            straps_held_reg <= 1'b0;
            div_strap_reg   <= DAPC_DIV1;
            mode_strap_reg  <= DAPC_OUT_DIFF3;
            fmt_strap_reg   <= DAPC_FMT_OFFBIN;
            pwr_strap_reg   <= DAPC_PWR_NORMAL;
        end else if (!straps_held_reg && rcl_sync_reg[1]) begin
            straps_held_reg <= 1'b1; // [R24]
            unique case (dapc_strap_e'(div_sync2_reg)) // [R01]
                DAPC_STRAP_LOW:  div_strap_reg <= DAPC_DIV2;
                DAPC_STRAP_HIGH: div_strap_reg <= DAPC_DIV4;
                default:         div_strap_reg <= DAPC_DIV1;
            endcase
            case (dapc_strap_e'(mode_sync2_reg)) // [R05]
                DAPC_STRAP_LOW:  mode_strap_reg <= DAPC_OUT_CMOS;
                DAPC_STRAP_HIGH: mode_strap_reg <= DAPC_OUT_DIFF2;
                default:         mode_strap_reg <= DAPC_OUT_DIFF3;
            endcase
            case (dapc_strap_e'(fmt_sync2_reg)) // [R16]
                DAPC_STRAP_LOW:  fmt_strap_reg <= DAPC_FMT_OFFBIN;
                DAPC_STRAP_HIGH: fmt_strap_reg <= DAPC_FMT_GRAY;
                default:         fmt_strap_reg <= DAPC_FMT_TWOS;
            endcase
            case (dapc_strap_e'(pwr_sync2_reg)) // [R14]
                DAPC_STRAP_LOW:  pwr_strap_reg <= DAPC_PWR_NORMAL;
                DAPC_STRAP_HIGH: pwr_strap_reg <= DAPC_PWR_NAP;
                default:         pwr_strap_reg <= DAPC_PWR_SLEEP;
            endcase
        end
    end

    // Serial settings win over straps; power override hits one converter
    assign div_sel      = serial_ovr.div_ovr  ? serial_ovr.div_val  : div_strap_reg;  // [R02]
    assign out_standard = serial_ovr.mode_ovr ? serial_ovr.mode_val : mode_strap_reg; // [R06]
    assign fmt_sel      = serial_ovr.fmt_ovr  ? serial_ovr.fmt_val  : fmt_strap_reg;  // [R17]
    assign pwr_a_sel = (serial_ovr.pwr_ovr && !serial_ovr.pwr_idx_b) ?
                       serial_ovr.pwr_val : pwr_a_reg; // [R15]
    assign pwr_b_sel = (serial_ovr.pwr_ovr && serial_ovr.pwr_idx_b) ?
                       serial_ovr.pwr_val : pwr_b_reg; // [R15]
    assign divide_ratio  = div_sel;
    assign power_state_a = pwr_a_reg;
    assign power_state_b = pwr_b_reg;

    // Per-converter power state; strap loads both at start
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_a_reg <= DAPC_PWR_NORMAL;
            pwr_b_reg <= DAPC_PWR_NORMAL;
        end else if (!straps_held_reg) begin
            pwr_a_reg <= pwr_strap_reg;
            pwr_b_reg <= pwr_strap_reg;
        end else begin
            pwr_a_reg <= (serial_ovr.pwr_ovr || !straps_held_reg) ? pwr_a_sel : pwr_strap_reg;
            pwr_b_reg <= (serial_ovr.pwr_ovr || !straps_held_reg) ? pwr_b_sel : pwr_strap_reg;
        end
    end

    // Sample rate enable from divider; a ratio change in ST_RUN starts the lock wait
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            div_cnt_reg  <= 2'h0;
            div_last_reg <= DAPC_DIV1;
        end else begin
            div_last_reg <= div_sel;
            if (sample_en) begin
                div_cnt_reg <= 2'h0;
            end else begin
                div_cnt_reg <= div_cnt_reg + 2'h1;
            end
        end
    end
    always_comb begin
        case (div_sel) // [R01]
            DAPC_DIV2: sample_en = (div_cnt_reg == DAPC_DIV2);
            DAPC_DIV4: sample_en = (div_cnt_reg == DIV4_LAST);
            default:   sample_en = 1'b1;
        endcase
    end

    // Remember a sleep so the long wake delay applies, nap wakes fast
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            deep_reg <= 1'b0;
        end else if (pwr_a_reg == DAPC_PWR_SLEEP || pwr_b_reg == DAPC_PWR_SLEEP) begin
            deep_reg <= 1'b1;
        end else if (pwr_st_reg == ST_WAKE) begin
            deep_reg <= 1'b0;
        end
    end

    // Power sequencer: low power, wake delay, run; relock from run after a ratio change
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            pwr_st_reg <= ST_LOW;
            wait_reg   <= '0;
        end else begin
            case (pwr_st_reg)
                ST_RUN: begin
                    if (pwr_a_reg != DAPC_PWR_NORMAL || pwr_b_reg != DAPC_PWR_NORMAL) begin
                        pwr_st_reg <= ST_LOW;
                    end else if (div_sel != div_last_reg) begin
                        pwr_st_reg <= ST_LOCK; // [R03]
                        wait_reg   <= CW'(LOCK_CYC);
                    end
                end
                ST_LOW: begin
                    if (straps_held_reg && pwr_a_reg == DAPC_PWR_NORMAL &&
                        pwr_b_reg == DAPC_PWR_NORMAL) begin
                        pwr_st_reg <= ST_WAKE; // [R08]
                        wait_reg   <= deep_reg ? CW'(SLEEP_CYC) : CW'(NAP_CYC);
                    end
                end
                ST_WAKE, ST_LOCK: begin
                    if (pwr_a_reg != DAPC_PWR_NORMAL || pwr_b_reg != DAPC_PWR_NORMAL) begin
                        pwr_st_reg <= ST_LOW;
                    end else if (wait_reg <= CW'(1)) begin
                        pwr_st_reg <= ST_RUN;
                    end else begin
                        wait_reg <= wait_reg - CW'(1);
                    end
                end
                default: pwr_st_reg <= ST_LOW;
            endcase
        end
    end
    assign awake = (pwr_st_reg == ST_RUN);

    // Encode each channel; all-ones full scale stays all ones only in offset binary
    function automatic logic [W-1:0] dapc_enc(input logic [W-1:0] v, input logic [1:0] f);
        case (f)
            DAPC_FMT_TWOS: dapc_enc = {~v[W-1], v[W-2:0]};   // [R18]
            DAPC_FMT_GRAY: dapc_enc = v ^ (v >> 1);          // [R19]
            default:       dapc_enc = v;                     // [R18]
        endcase
    endfunction
    assign enc_a = dapc_enc(raw_a, fmt_sel); // [R23]
    assign enc_b = dapc_enc(raw_b, fmt_sel); // [R20]
    assign fifo_in = '{a: enc_a, b: enc_b};
    assign fifo_pop = fifo_out_valid && sample_en && awake && lat_valid_reg[0] && !pend_reg;

    dapc_fifo #(
        .WIDTH (2*W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .mclk      (mclk),
        .rst_b     (rst_b),
        .in_data   (fifo_in),
        .in_valid  (raw_valid && awake),
        .in_ready  (raw_ready),
        .out_data  (fifo_out),
        .out_valid (fifo_out_valid),
        .out_ready (fifo_pop)
    );

    // Pipeline fill delay; half cycle comes from the DDR phase
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            lat_valid_reg <= '0;
        end else if (!awake) begin
            lat_valid_reg <= '0;
        end else if (sample_en) begin
            lat_valid_reg <= {fifo_out_valid, lat_valid_reg[$bits(lat_valid_reg)-1:1]}; // [R21]
        end
    end

    // DDR phase: A on low half, B on high half; pend marks B still owed
    always_ff @(posedge mclk or negedge rst_b) begin
        if (!rst_b) begin
            phase_reg   <= 1'b0;
            pend_reg    <= 1'b0;
            out_data    <= '0;
            hold_b_reg  <= '0;
            or_b_reg    <= 1'b0;
            over_range  <= 1'b0;
        end else if (!rcl_sync_reg[1]) begin
            phase_reg   <= 1'b0;       // [R22]
            pend_reg    <= 1'b0;
            over_range  <= 1'b1;
        end else if (fifo_pop) begin
            phase_reg   <= 1'b0;
            pend_reg    <= 1'b1;
            out_data    <= fifo_out.a; // [R04]
            hold_b_reg  <= fifo_out.b;
            over_range  <= (fifo_out.a == dapc_enc(FULL_SCALE, fmt_sel)); // [R07]
            or_b_reg    <= (fifo_out.b == dapc_enc(FULL_SCALE, fmt_sel));
        end else if (pend_reg) begin
            phase_reg   <= 1'b1;
            pend_reg    <= 1'b0;
            out_data    <= hold_b_reg; // [R04]
            over_range  <= or_b_reg;   // [R07]
        end else begin
            phase_reg   <= 1'b0;
        end
    end
    assign forwarded_sample_clock = phase_reg && rcl_sync_reg[1] && awake; // [R22]
    assign out_data_oe = awake; // [R12]

    // Select pin only observed; waking hinges on host write, not select timing
    logic unused_sel;
    assign unused_sel = sel_sync_reg[1]; // [R10]
endmodule
`default_nettype wire

// ==== sim/dapc_capture.sv ====
`default_nettype none
module dapc_capture
    import dapc_pkg::*;
(
    input  wire logic                   mclk,
    input  wire logic                   rst_b,
    input  wire logic [DAPC_WORD_W-1:0] out_data,
    input  wire logic                   out_data_oe,
    input  wire logic                   over_range,
    input  wire logic                   forwarded_sample_clock
);
    timeunit 1ns;
    timeprecision 1ns;
    dapc_pair_s             q[$];
    logic [1:0]             rq[$];
    logic [DAPC_WORD_W-1:0] a_hold;
    logic                   or_hold;
    // A in the low phase, B in the high phase; a floated bus is never captured
    always @(posedge mclk) begin
        if (rst_b && out_data_oe === 1'b1) begin
            if (forwarded_sample_clock === 1'b0) begin
                a_hold = out_data;
                or_hold = over_range;
            end else begin
                q.push_back('{a: a_hold, b: out_data});
                rq.push_back({or_hold, over_range});
            end
        end
    end
endmodule
`default_nettype wire

// ==== sim/dapc_ctrl_chk.sv ====
`default_nettype none
module dapc_ctrl_chk
    import dapc_pkg::*;
(
    input  wire logic       mclk,
    input  wire logic       rst_b,
    input  wire dapc_ovr_s  serial_ovr,
    input  wire logic       recal_reset_n,
    input  wire logic       raw_ready,
    input  wire logic       out_data_oe,
    input  wire logic       forwarded_sample_clock,
    input  wire logic       over_range,
    input  wire logic [1:0] out_standard,
    input  wire logic [1:0] divide_ratio,
    input  wire logic [1:0] power_state_a,
    input  wire logic [1:0] power_state_b,
    input  wire logic       awake
);
    timeunit 1ns;
    timeprecision 1ns;
    default clocking cb @(posedge mclk); endclocking
    default disable iff (!rst_b);
    // Settled serial settings must win over the straps
    chk_div_follow: assert property (
        (serial_ovr.div_ovr && $stable(serial_ovr.div_val)) [*3]
        |-> divide_ratio == serial_ovr.div_val) else $error("divider ignores override");
    chk_mode_follow: assert property (
        (serial_ovr.mode_ovr && $stable(serial_ovr.mode_val)) [*3]
        |-> out_standard == serial_ovr.mode_val) else $error("standard ignores override");
    // Register lags one cycle; the setting must hold six cycles first
    chk_pwr_index: assert property (
        (serial_ovr.pwr_ovr && $stable(serial_ovr)) [*6]
        |-> (serial_ovr.pwr_idx_b ? power_state_b : power_state_a) == serial_ovr.pwr_val)
        else $error("power override missed converter");
    chk_float_idle: assert property (
        (power_state_a != DAPC_PWR_NORMAL && power_state_b != DAPC_PWR_NORMAL)
        |-> !out_data_oe) else $error("bus driven in low power");
    chk_ddr_phase: assert property (
        forwarded_sample_clock |=> !forwarded_sample_clock) else $error("high phase too long");
    // Recal input passes a synchroniser, hence five samples
    chk_recal_clock: assert property (
        !recal_reset_n [*5] |-> !forwarded_sample_clock) else $error("clock runs in recal");
    chk_recal_flag: assert property (
        !recal_reset_n [*5] |-> over_range) else $error("flag low in recal");
    chk_nap_wake: assert property (
        (($past(power_state_a) == DAPC_PWR_NAP || $past(power_state_b) == DAPC_PWR_NAP)
         && power_state_a == DAPC_PWR_NORMAL && power_state_b == DAPC_PWR_NORMAL)
         |-> ##[0:48] awake)
        else $error("nap wake too slow");
    cov_wake: cover property ($rose(awake));
    cov_full: cover property ($fell(raw_ready));
    cov_range: cover property (over_range && out_data_oe);
endmodule
bind dapc_ctrl dapc_ctrl_chk u_dapc_ctrl_chk (
    .mclk(mclk), .rst_b(rst_b), .serial_ovr(serial_ovr), .recal_reset_n(recal_reset_n),
    .raw_ready(raw_ready), .out_data_oe(out_data_oe),
    .forwarded_sample_clock(forwarded_sample_clock), .over_range(over_range),
    .out_standard(out_standard), .divide_ratio(divide_ratio),
    .power_state_a(power_state_a), .power_state_b(power_state_b), .awake(awake)
);
`default_nettype wire

// ==== sim/dual_adc_output_power_ctrl_test.sv ====
`default_nettype none
module dual_adc_output_power_ctrl_test;
    import dapc_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic       mclk = 0, rst_b = 0, raw_valid = 0, raw_ready, out_data_oe;
    logic       serial_select_n = 1, recal_reset_n = 1, fsc, over_range, awake;
    logic [1:0] div_s = 0, std_s = 0, fmt_s = 0, pwr_s = 0;
    logic [1:0] out_standard, divide_ratio, power_state_a, power_state_b;
    logic [9:0] raw_a = 0, raw_b = 0, out_data, a, b;
    dapc_ovr_s  serial_ovr = '0;
    dapc_pair_s exp_q[$];
    dapc_pair_s e, g;
    logic [1:0] r;
    int         miscompares = 0, total_checks = 0, seed = 32'h9c9ddd78, n;
    logic [1:0] dtab[3] = '{DAPC_DIV2, DAPC_DIV1, DAPC_DIV4};
    logic [1:0] ptab[3] = '{DAPC_PWR_NORMAL, DAPC_PWR_SLEEP, DAPC_PWR_NAP};
    logic [1:0] stab[3] = '{DAPC_OUT_CMOS, DAPC_OUT_DIFF3, DAPC_OUT_DIFF2};
    // Short wake and lock counts keep the run brief
    dapc_ctrl #(.SLEEP_CYC(10), .LOCK_CYC(10)) u_dapc_ctrl (
        .mclk(mclk), .rst_b(rst_b), .clock_divide_strap(div_s),
        .output_standard_strap(std_s), .code_format_strap(fmt_s),
        .power_state_strap(pwr_s), .serial_ovr(serial_ovr),
        .serial_select_n(serial_select_n), .recal_reset_n(recal_reset_n),
        .raw_a(raw_a), .raw_b(raw_b), .raw_valid(raw_valid), .raw_ready(raw_ready),
        .out_data(out_data), .out_data_oe(out_data_oe), .forwarded_sample_clock(fsc),
        .over_range(over_range), .out_standard(out_standard), .divide_ratio(divide_ratio),
        .power_state_a(power_state_a), .power_state_b(power_state_b), .awake(awake));
    dapc_capture u_dapc_capture (.mclk(mclk), .rst_b(rst_b), .out_data(out_data),
        .out_data_oe(out_data_oe), .over_range(over_range), .forwarded_sample_clock(fsc));
    // 40 MHz clock
    initial begin
        forever #12.5 mclk = ~mclk;
    end
    task automatic check(input string name, input logic [19:0] seen, input logic [19:0] exp);
        total_checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && total_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    // Straps only latch after reset, so every strap change goes through one
    task automatic do_reset(input logic [1:0] v);
        @(negedge mclk);
        rst_b = 0;
        {div_s, std_s, fmt_s, pwr_s} = {4{v}};
        repeat (2) @(negedge mclk);
        rst_b = 1;
    endtask
    task automatic wait_awake();
        n = 0;
        while (awake !== 1'b1 && n < 300) begin
            @(negedge mclk);
            n++;
        end
    endtask
    // Valid stays up across back-to-back pushes; ready is looked at mid-cycle
    task automatic push(input logic [9:0] va, input logic [9:0] vb);
        int t;
        t = 0;
        raw_a = va;
        raw_b = vb;
        raw_valid = 1;
        while (!(raw_ready === 1'b1 && awake === 1'b1) && t < 400) begin
            t++;
            @(negedge mclk);
        end
        @(negedge mclk);
    endtask
    function automatic logic [9:0] enc(input int f, input logic [9:0] v);
        if (f == 1)
            return {~v[9], v[8:0]};
        if (f == 2)
            return v ^ (v >> 1);
        return v;
    endfunction
    // Watchdog against a hang
    initial begin
        #150000;
        miscompares++;
        report_and_stop();
    end
    initial begin
        repeat (2) @(negedge mclk);
        rst_b = 1;
        // Strap decode for high, float and low
        for (int v = 2; v >= 0; v--) begin
            do_reset(v[1:0]);
            repeat (6) @(negedge mclk);
            check("div", divide_ratio, dtab[v]);
            check("std", out_standard, stab[v]);
            check("pwr_a", power_state_a, ptab[v]);
            check("pwr_b", power_state_b, ptab[v]);
            if (v != 0)
                check("oe_low", out_data_oe, 0);
            wait_awake();
            check("awake", awake, v == 0);
        end
        serial_ovr.div_ovr = 1;
        serial_ovr.div_val = DAPC_DIV4;
        serial_ovr.mode_ovr = 1;
        serial_ovr.mode_val = DAPC_OUT_DIFF2;
        repeat (3) @(negedge mclk);
        check("div_ovr", divide_ratio, DAPC_DIV4);
        check("std_ovr", out_standard, DAPC_OUT_DIFF2);
        check("relock", awake, 0);
        // Indexed power control touches only the chosen converter
        serial_ovr.pwr_ovr = 1;
        serial_ovr.pwr_idx_b = 1;
        serial_ovr.pwr_val = DAPC_PWR_NAP;
        repeat (8) @(negedge mclk);
        check("ovr_b", power_state_b, DAPC_PWR_NAP);
        check("keep_a", power_state_a, DAPC_PWR_NORMAL);
        serial_ovr.pwr_val = DAPC_PWR_NORMAL;
        wait_awake();
        check("nap_time", n >= 36 && n <= 48, 1);
        serial_ovr.pwr_idx_b = 0;
        serial_ovr.pwr_val = DAPC_PWR_SLEEP;
        repeat (8) @(negedge mclk);
        check("ovr_a", power_state_a, DAPC_PWR_SLEEP);
        // Select driven low before the wake write, then high again; clock kept running while asleep
        check("sleep_oe", out_data_oe, 0);
        serial_select_n = 0;
        repeat (6) @(negedge mclk);
        serial_ovr.pwr_val = DAPC_PWR_NORMAL;
        @(negedge mclk);
        serial_select_n = 1;
        wait_awake();
        check("sleep_wake", awake, 1);
        recal_reset_n = 0;
        repeat (6) @(negedge mclk);
        check("rc_clk", fsc, 0);
        check("rc_flag", over_range, 1);
        recal_reset_n = 1;
        // Bursts faster than the output drains, one per format
        for (int f = 0; f < 3; f++) begin
            serial_ovr.fmt_ovr = 1;
            serial_ovr.fmt_val = f[1:0];
            wait_awake();
            repeat (30) @(negedge mclk);
            u_dapc_capture.q.delete();
            u_dapc_capture.rq.delete();
            for (int i = 0; i < 60; i++) begin
                a = (i == 0) ? 10'h200 : (i == 1) ? 10'h000 : 10'($random(seed));
                b = (i == 0) ? 10'h3ff : (i == 1) ? 10'h001 : 10'($random(seed));
                push(a, b);
                exp_q.push_back('{a: enc(f, a), b: enc(f, b)});
            end
            raw_valid = 0;
            repeat (250) @(negedge mclk);
            while (exp_q.size() > 0) begin
                e = exp_q.pop_front();
                g = 'x;
                r = 'x;
                if (u_dapc_capture.q.size() > 0) begin
                    g = u_dapc_capture.q.pop_front();
                    r = u_dapc_capture.rq.pop_front();
                end
                check("pair", g, e);
                check("range", r, {e.a == enc(f, 10'h3ff), e.b == enc(f, 10'h3ff)});
            end
        end
        report_and_stop();
    end
endmodule
`default_nettype wire
